// file: inc/ptpi_cfg.svh
// Constants for the pulse train process image: field positions, limits and timing.
// Assumes inclusion by bare name from the package and the design file.
`ifndef PTPI_CFG_SVH
`define PTPI_CFG_SVH

// Control word bit positions
`define PTPI_CTRL_FREQ_SEL 0
`define PTPI_CTRL_RAMP_INHIBIT 1
`define PTPI_CTRL_TRAVEL_GO 2

// Status word bit positions
`define PTPI_STAT_ACK 0
`define PTPI_STAT_RAMP 1
`define PTPI_STAT_TARGET 4
`define PTPI_STAT_ZERO 5
`define PTPI_STAT_ERROR 6
`define PTPI_STAT_SYNC 13
`define PTPI_STAT_TOGGLE 15

// Reset values
`define PTPI_RST_WORD16 16'h0000
`define PTPI_RST_WORD32 32'h0000_0000

// Wrap limits of the low 16-bit half of the position counter
`define PTPI_CNT_MAX 16'hffff
`define PTPI_CNT_ZERO 16'h0000
`define PTPI_OVF_CLR_FROM 16'h5555
`define PTPI_OVF_CLR_TO 16'h5556
`define PTPI_UNF_CLR_FROM 16'haaaa
`define PTPI_UNF_CLR_TO 16'haaa9

// Base frequency scaling: phase increment is |freq| shifted left by this amount
`define PTPI_BASE1_SHIFT 5'h04
`define PTPI_BASE2_SHIFT 5'h08

// Ramp: one step of this size per ramp tick
`define PTPI_RAMP_STEP 16'h0010
`define PTPI_CLK_PERIOD_NS 10
`define PTPI_RAMP_TICK_NS 1000
`define PTPI_RAMP_TICK_CYC (`PTPI_RAMP_TICK_NS / `PTPI_CLK_PERIOD_NS)

`endif

// file: inc/ptpi_pkg.sv
// Types of the pulse train process image.
// Assumes ptpi_cfg.svh is on the include path.
`include "ptpi_cfg.svh"

package ptpi_pkg;

  // Output image written by the fieldbus master
  typedef struct packed {
    logic [15:0] output_control_word;
    logic [15:0] commanded_frequency;
    logic [31:0] travel_target_count;
    logic set_counter;
    logic [31:0] counter_preset;
  } ptpi_out_img_t;

  // Input image returned to the master
  typedef struct packed {
    logic [15:0] input_status_word;
    logic [15:0] input_counter_word;
    logic counter_load_done;
    logic counter_wrap_down_flag;
    logic counter_wrap_up_flag;
    logic encoder_sync_fault;
    logic encoder_update_toggle;
    logic [31:0] position_count;
  } ptpi_in_img_t;

  typedef enum logic [1:0] {
    PTPI_FREE = 2'b00,
    PTPI_MOVE = 2'b01,
    PTPI_DONE = 2'b10
  } ptpi_travel_t;

endpackage : ptpi_pkg

// file: rtl/ptpi_pulse_train.sv
// Pulse train output channel with position counter and its process data image.
// Assumes the image ports come from fieldbus logic on core_clk_i; pd_cycle_i marks
// each process data exchange. Target and zero pins are asynchronous.
//
// Behaviour
// - Ack flag shows base frequency change applied
// - In travel mode, ack means target reached
// - Ramp flag high while frequency is ramping
// - Error flag follows overflow or underflow flag
// - Sync fault only in distributed clock mode
// - Update toggle inverts on every image refresh
// - Underflow set on wrap from zero down
// - Underflow cleared at 43690-to-43689 or overflow
// - Overflow set on wrap from maximum up
// - Overflow cleared at 21845-to-21846 or underflow
// - Report target input level in status
// - Report zero input level in status
// - Low counter half goes into data word
// - Select bit picks base frequency one/two
// - Ramp inhibit bit suppresses configured ramp
// - Ramp inhibit aborts a running travel move
// - Go bit drives pulses until target count
// - Output data word is commanded frequency
// - Set-counter command loads preset into counter
`include "ptpi_cfg.svh"
module ptpi_pulse_train
  import ptpi_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Process data exchange
  input wire logic pd_cycle_i,
  input wire ptpi_out_img_t out_img_i,
  output ptpi_in_img_t in_img_o,
  // Configuration
  input wire logic ramp_cfg_en_i,
  input wire logic travel_cfg_en_i,
  input wire logic dc_mode_i,
  input wire logic sync_err_evt_i,
  // Pins
  input wire logic target_pin_i,
  input wire logic zero_pin_i,
  output logic pulse_o,
  output logic dir_o
);

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_b;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_b = rst_sync_reg;

  // Pin synchronisers
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_reg <= 2'b00;
      pin_sync_reg <= 2'b00;
    end else begin
      pin_meta_reg <= {zero_pin_i, target_pin_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Output image latched once per exchange so a move sees stable commands
  ptpi_out_img_t cmd_reg;

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      cmd_reg <= '0;
    end else if (pd_cycle_i) begin
      cmd_reg <= out_img_i;
    end
  end

  logic freq_sel;
  logic ramp_inhibit;
  logic travel_go;
  logic ramp_on;
  assign freq_sel = cmd_reg.output_control_word[`PTPI_CTRL_FREQ_SEL];
  assign ramp_inhibit = cmd_reg.output_control_word[`PTPI_CTRL_RAMP_INHIBIT];
  assign travel_go = cmd_reg.output_control_word[`PTPI_CTRL_TRAVEL_GO];
  assign ramp_on = ramp_cfg_en_i && !ramp_inhibit;

  // Base frequency choice takes effect only while ramping is off
  logic sel_applied_reg;

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      sel_applied_reg <= 1'b0;
    end else if (!ramp_on) begin
      sel_applied_reg <= freq_sel;
    end
  end

  // Travel distance control
  ptpi_travel_t travel_reg;
  logic [31:0] count_reg;
  logic at_target;
  assign at_target = (count_reg == cmd_reg.travel_target_count);

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      travel_reg <= PTPI_FREE;
    end else if (!travel_cfg_en_i) begin
      travel_reg <= PTPI_FREE;
    end else begin
      unique case (travel_reg)
        PTPI_FREE: begin
          if (travel_go && !ramp_inhibit) begin
            travel_reg <= at_target ? PTPI_DONE : PTPI_MOVE;
          end
        end
        PTPI_MOVE: begin
          if (ramp_inhibit) begin
            travel_reg <= PTPI_FREE;
          end else if (at_target) begin
            travel_reg <= PTPI_DONE;
          end
        end
        PTPI_DONE: begin
          if (!travel_go) begin
            travel_reg <= PTPI_FREE;
          end
        end
        default: begin
          travel_reg <= PTPI_FREE;
        end
      endcase
    end
  end

  // Goal frequency, signed
  logic signed [15:0] req_freq;
  logic [15:0] req_mag;
  logic signed [15:0] goal_freq;
  assign req_freq = cmd_reg.commanded_frequency;
  assign req_mag = req_freq[15] ? 16'(-req_freq) : 16'(req_freq);

  always_comb begin
    if (!travel_cfg_en_i) begin
      goal_freq = req_freq;
    end else if (travel_reg == PTPI_MOVE && !at_target) begin
      goal_freq = (cmd_reg.travel_target_count > count_reg) ? req_mag : 16'(-req_mag);
    end else begin
      goal_freq = 16'h0000;
    end
  end

  // Ramp tick divider
  logic [$clog2(`PTPI_RAMP_TICK_CYC)-1:0] tick_cnt_reg;
  logic ramp_tick;
  assign ramp_tick = (tick_cnt_reg == '0);

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_reg <= '0;
    end else if (ramp_tick) begin
      tick_cnt_reg <= ($clog2(`PTPI_RAMP_TICK_CYC))'(`PTPI_RAMP_TICK_CYC - 1);
    end else begin
      tick_cnt_reg <= tick_cnt_reg - 1'b1;
    end
  end

  // Current output frequency; a stop at target is immediate to avoid overshoot
  logic signed [15:0] cur_freq_reg;
  logic signed [16:0] freq_diff;
  assign freq_diff = 17'(goal_freq) - 17'(cur_freq_reg);

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      cur_freq_reg <= 16'h0000;
    end else if (!ramp_on || (travel_cfg_en_i && (travel_reg != PTPI_MOVE || at_target))) begin
      cur_freq_reg <= goal_freq;
    end else if (ramp_tick) begin
      if (freq_diff > 17'($signed(`PTPI_RAMP_STEP))) begin
        cur_freq_reg <= cur_freq_reg + $signed(`PTPI_RAMP_STEP);
      end else if (freq_diff < -17'($signed(`PTPI_RAMP_STEP))) begin
        cur_freq_reg <= cur_freq_reg - $signed(`PTPI_RAMP_STEP);
      end else begin
        cur_freq_reg <= goal_freq;
      end
    end
  end

  logic ramp_active;
  assign ramp_active = ramp_on && (cur_freq_reg != goal_freq);

  // Phase accumulator; its top bit is the pulse waveform
  logic [15:0] cur_mag;
  logic [4:0] base_shift;
  logic [31:0] phase_inc;
  logic [31:0] phase_reg;
  logic [31:0] phase_next;
  assign cur_mag = cur_freq_reg[15] ? 16'(-cur_freq_reg) : 16'(cur_freq_reg);
  assign base_shift = sel_applied_reg ? `PTPI_BASE2_SHIFT : `PTPI_BASE1_SHIFT;
  assign phase_inc = {16'h0000, cur_mag} << base_shift;
  assign phase_next = phase_reg + phase_inc;

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= `PTPI_RST_WORD32;
      pulse_o <= 1'b0;
      dir_o <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      pulse_o <= phase_next[31];
      if (cur_mag != 16'h0000) begin
        dir_o <= cur_freq_reg[15];
      end
    end
  end

  logic pulse_edge;
  assign pulse_edge = phase_next[31] && !pulse_o;

  // Position counter and wrap flags with hysteresis
  logic load_done_reg;
  logic ovf_reg;
  logic unf_reg;
  logic step_up;
  logic step_dn;
  logic [15:0] cnt_lo;
  assign step_up = pulse_edge && !cur_freq_reg[15];
  assign step_dn = pulse_edge && cur_freq_reg[15];
  assign cnt_lo = count_reg[15:0];

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= `PTPI_RST_WORD32;
    end else if (cmd_reg.set_counter && !load_done_reg) begin
      count_reg <= cmd_reg.counter_preset;
    end else if (step_up) begin
      count_reg <= count_reg + 32'h1;
    end else if (step_dn) begin
      count_reg <= count_reg - 32'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      load_done_reg <= 1'b0;
    end else begin
      load_done_reg <= cmd_reg.set_counter;
    end
  end

  logic wrap_up;
  logic wrap_dn;
  assign wrap_up = step_up && (cnt_lo == `PTPI_CNT_MAX) && !(cmd_reg.set_counter && !load_done_reg);
  assign wrap_dn = step_dn && (cnt_lo == `PTPI_CNT_ZERO) && !(cmd_reg.set_counter && !load_done_reg);

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      ovf_reg <= 1'b0;
    end else if (wrap_up) begin
      ovf_reg <= 1'b1;
    end else if (wrap_dn || (step_up && cnt_lo == `PTPI_OVF_CLR_FROM)) begin
      ovf_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      unf_reg <= 1'b0;
    end else if (wrap_dn) begin
      unf_reg <= 1'b1;
    end else if (wrap_up || (step_dn && cnt_lo == `PTPI_UNF_CLR_FROM)) begin
      unf_reg <= 1'b0;
    end
  end

  // Sync errors collected over one exchange cycle; a new event wins over the clear
  logic sync_seen_reg;

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      sync_seen_reg <= 1'b0;
    end else if (sync_err_evt_i) begin
      sync_seen_reg <= 1'b1;
    end else if (pd_cycle_i) begin
      sync_seen_reg <= 1'b0;
    end
  end

  // Image refresh, once per exchange
  logic [15:0] status_next;
  logic ack_bit;
  assign ack_bit = travel_cfg_en_i ? (travel_reg == PTPI_DONE) : sel_applied_reg;

  always_comb begin
    status_next = 16'h0000;
    status_next[`PTPI_STAT_ACK] = ack_bit;
    status_next[`PTPI_STAT_RAMP] = ramp_active;
    status_next[`PTPI_STAT_TARGET] = pin_sync_reg[0];
    status_next[`PTPI_STAT_ZERO] = pin_sync_reg[1];
    status_next[`PTPI_STAT_ERROR] = ovf_reg || unf_reg;
    status_next[`PTPI_STAT_SYNC] = dc_mode_i && (sync_seen_reg || sync_err_evt_i);
    status_next[`PTPI_STAT_TOGGLE] = !in_img_o.input_status_word[`PTPI_STAT_TOGGLE];
  end

  always_ff @(posedge core_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      in_img_o <= '0;
    end else if (pd_cycle_i) begin
      in_img_o.input_status_word <= status_next;
      in_img_o.input_counter_word <= count_reg[15:0];
      in_img_o.counter_load_done <= load_done_reg;
      in_img_o.counter_wrap_down_flag <= unf_reg;
      in_img_o.counter_wrap_up_flag <= ovf_reg;
      in_img_o.encoder_sync_fault <= status_next[`PTPI_STAT_SYNC];
      in_img_o.encoder_update_toggle <= !in_img_o.encoder_update_toggle;
      in_img_o.position_count <= count_reg;
    end
  end

  // Checks
  a_wrap_down_set: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    wrap_dn |=> unf_reg && !ovf_reg) else $error("underflow not set on wrap down");
  a_unf_clear: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    step_dn && cnt_lo == 16'haaaa && !wrap_up |=> !unf_reg) else $error("underflow not cleared");
  a_wrap_up_set: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    wrap_up |=> ovf_reg && !unf_reg) else $error("overflow not set on wrap up");
  a_ovf_clear: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    step_up && cnt_lo == 16'h5555 |=> !ovf_reg) else $error("overflow not cleared");
  a_error_image: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    pd_cycle_i |=> in_img_o.input_status_word[6] == (in_img_o.counter_wrap_up_flag
    || in_img_o.counter_wrap_down_flag)) else $error("error bit mismatch");
  a_toggle_flip: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    pd_cycle_i |=> in_img_o.input_status_word[15] != $past(in_img_o.input_status_word[15]))
    else $error("toggle not inverted");
  a_toggle_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    !pd_cycle_i |=> $stable(in_img_o)) else $error("image changed outside exchange");
  a_sync_mode: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    pd_cycle_i && !dc_mode_i |=> !in_img_o.input_status_word[13]) else $error("sync fault outside dc");
  a_counter_load: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    cmd_reg.set_counter && !load_done_reg |=> count_reg == $past(cmd_reg.counter_preset) ##0 load_done_reg)
    else $error("preset not loaded");
  a_count_step: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    step_up && !(cmd_reg.set_counter && !load_done_reg) |=> count_reg == $past(count_reg) + 32'h1)
    else $error("count did not step");
  a_abort_move: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    travel_reg == PTPI_MOVE && ramp_inhibit |=> travel_reg == PTPI_FREE) else $error("move not aborted");
  a_no_ramp: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    !ramp_on |=> cur_freq_reg == $past(goal_freq)) else $error("ramp while inhibited");
  a_sel_apply: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    !ramp_on ##1 !ramp_on |-> sel_applied_reg == $past(freq_sel)) else $error("select not applied");
  a_travel_halt: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    travel_cfg_en_i && travel_reg == PTPI_MOVE && at_target |=> cur_freq_reg == 16'h0000) else $error("no stop at target");
  a_dir_follow: assert property (@(posedge core_clk_i) disable iff (!rst_b)
    cur_freq_reg != 16'h0000 |=> dir_o == $past(cur_freq_reg[15])) else $error("direction not followed");
  c_travel_abort: cover property (@(posedge core_clk_i) disable iff (!rst_b)
    travel_reg == PTPI_MOVE ##1 travel_reg == PTPI_FREE);
  c_travel_done: cover property (@(posedge core_clk_i) disable iff (!rst_b)
    travel_reg == PTPI_MOVE ##1 travel_reg == PTPI_DONE);
  c_wrap_up: cover property (@(posedge core_clk_i) disable iff (!rst_b) wrap_up);
  c_wrap_down: cover property (@(posedge core_clk_i) disable iff (!rst_b) wrap_dn);
  c_ramping: cover property (@(posedge core_clk_i) disable iff (!rst_b) ramp_active [*3]);

endmodule : ptpi_pulse_train

// file: verif/ptpi_drive_model.sv
// Behavioural stepper drive that listens to the pulse train output.
// Assumes pulse and direction come from registers on the same clock as the channel.
module ptpi_drive_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Pulse interface from the channel
  input wire logic pulse_i,
  input wire logic dir_i,
  // Observation for the bench
  output logic [31:0] steps_o,
  output logic [31:0] period_o,
  output logic [31:0] pos_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic pulse_q;
  logic [31:0] gap_q;

  // A drive steps once per rising edge, in the direction held at that moment
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_q <= 1'b0;
      gap_q <= 32'h0000_0000;
      steps_o <= 32'h0000_0000;
      period_o <= 32'h0000_0000;
      pos_o <= 32'h0000_0000;
    end else begin
      pulse_q <= pulse_i;
      gap_q <= gap_q + 32'h0000_0001;
      if (pulse_i && !pulse_q) begin
        steps_o <= steps_o + 32'h0000_0001;
        pos_o <= dir_i ? pos_o - 32'h0000_0001 : pos_o + 32'h0000_0001;
        period_o <= gap_q + 32'h0000_0001;
        gap_q <= 32'h0000_0000;
      end
    end
  end
endmodule : ptpi_drive_model

// file: verif/pulse_train_process_image_bench.sv
// Self-checking bench for the pulse train process image channel.
// Assumes the package and the cfg header are compiled first; drives the master side itself.
`include "ptpi_cfg.svh"
module pulse_train_process_image_bench
  import ptpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk_i, rst_b_i, pd_cycle_i, ramp_cfg_en_i, travel_cfg_en_i;
  logic dc_mode_i, sync_err_evt_i, target_pin_i, zero_pin_i, pulse_o, dir_o;
  ptpi_out_img_t out_img_i;
  ptpi_in_img_t in_img_o;
  logic [31:0] steps, period, pos, exp_pos;
  int num_errors = 0;
  int check_count = 0;

  ptpi_pulse_train DUT (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .pd_cycle_i(pd_cycle_i),
    .out_img_i(out_img_i), .in_img_o(in_img_o), .ramp_cfg_en_i(ramp_cfg_en_i),
    .travel_cfg_en_i(travel_cfg_en_i), .dc_mode_i(dc_mode_i), .sync_err_evt_i(sync_err_evt_i),
    .target_pin_i(target_pin_i), .zero_pin_i(zero_pin_i), .pulse_o(pulse_o), .dir_o(dir_o)
  );

  ptpi_drive_model drive (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .pulse_i(pulse_o), .dir_i(dir_o),
    .steps_o(steps), .period_o(period), .pos_o(pos)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic bchk(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask : bchk

  task automatic conclude;
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // One image exchange; gap lets one-cycle-late status settle first
  task automatic strobe;
    repeat (3) @(posedge core_clk_i);
    #1 pd_cycle_i = 1'b1;
    @(posedge core_clk_i);
    #1 pd_cycle_i = 1'b0;
  endtask : strobe

  // Mode 0 stops by zero frequency, 1 lets travel stop itself, 2 aborts by inhibit
  task automatic run(input logic [15:0] f, input int n, input int mode);
    logic [31:0] s0;
    logic [31:0] p0;
    int k;
    s0 = steps;
    p0 = pos;
    out_img_i.commanded_frequency = f;
    strobe();
    k = 0;
    while (steps - s0 < 32'(n) && k < 40000) begin
      @(posedge core_clk_i);
      k++;
    end
    #1;
    if (mode == 2) out_img_i.output_control_word[`PTPI_CTRL_RAMP_INHIBIT] = 1'b1;
    else if (mode == 0) out_img_i.commanded_frequency = 16'h0000;
    strobe();
    if (mode != 0) begin
      repeat (2100) @(posedge core_clk_i);
      #1;
    end
    out_img_i.commanded_frequency = 16'h0000;
    strobe();
    cmp(steps - s0, 32'(n));
    cmp(pos - p0, f[15] ? -32'(n) : 32'(n));
    exp_pos = f[15] ? exp_pos - 32'(n) : exp_pos + 32'(n);
  endtask : run

  task automatic chk_cnt(input logic ovf, input logic unf);
    strobe();
    cmp(in_img_o.position_count, exp_pos);
    cmp({16'h0, in_img_o.input_counter_word}, {16'h0, exp_pos[15:0]});
    bchk(in_img_o.counter_wrap_up_flag, ovf);
    bchk(in_img_o.counter_wrap_down_flag, unf);
    bchk(in_img_o.input_status_word[`PTPI_STAT_ERROR], ovf | unf);
  endtask : chk_cnt

  task automatic preset(input logic [31:0] v);
    out_img_i.set_counter = 1'b1;
    out_img_i.counter_preset = v;
    strobe();
    strobe();
    bchk(in_img_o.counter_load_done, 1'b1);
    cmp(in_img_o.position_count, v);
    out_img_i.set_counter = 1'b0;
    strobe();
    exp_pos = v;
  endtask : preset

  initial begin
    {rst_b_i, pd_cycle_i, ramp_cfg_en_i, travel_cfg_en_i, dc_mode_i} = 5'h00;
    {sync_err_evt_i, target_pin_i, zero_pin_i} = 3'h0;
    out_img_i = '0;
    exp_pos = 32'h0000_0000;
    repeat (6) @(posedge core_clk_i);
    #1 rst_b_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    bchk(|in_img_o, 1'b0);
    strobe();
    cmp({16'h0, in_img_o.input_status_word}, 32'h0000_8000);
    bchk(in_img_o.encoder_update_toggle, 1'b1);
    strobe();
    cmp({16'h0, in_img_o.input_status_word}, 32'h0000_0000);
    for (int p = 0; p < 2; p++) begin
      target_pin_i = (p == 0);
      zero_pin_i = (p == 1);
      strobe();
      bchk(in_img_o.input_status_word[`PTPI_STAT_TARGET], p == 0);
      bchk(in_img_o.input_status_word[`PTPI_STAT_ZERO], p == 1);
    end
    zero_pin_i = 1'b0;
    for (int d = 0; d < 2; d++) begin
      dc_mode_i = d[0];
      sync_err_evt_i = 1'b1;
      @(posedge core_clk_i);
      #1 sync_err_evt_i = 1'b0;
      strobe();
      bchk(in_img_o.input_status_word[`PTPI_STAT_SYNC], d[0]);
      bchk(in_img_o.encoder_sync_fault, d[0]);
    end
    strobe();
    bchk(in_img_o.input_status_word[`PTPI_STAT_SYNC], 1'b0);
    dc_mode_i = 1'b0;
    run(16'hc000, 2, 0);
    cmp(period, 32'd16384);
    chk_cnt(1'b0, 1'b1);
    out_img_i.output_control_word[`PTPI_CTRL_FREQ_SEL] = 1'b1;
    run(16'h4000, 3, 0);
    cmp(period, 32'd1024);
    chk_cnt(1'b1, 1'b0);
    bchk(in_img_o.input_status_word[`PTPI_STAT_ACK], 1'b1);
    run(16'hc000, 2, 0);
    chk_cnt(1'b0, 1'b1);
    preset(32'h0000_aaab);
    run(16'hc000, 3, 0);
    chk_cnt(1'b0, 1'b0);
    preset(32'h0000_ffff);
    run(16'h4000, 1, 0);
    chk_cnt(1'b1, 1'b0);
    preset(32'h0000_5553);
    run(16'h4000, 2, 0);
    chk_cnt(1'b1, 1'b0);
    run(16'h4000, 1, 0);
    chk_cnt(1'b0, 1'b0);
    // Travel to a target, then an aborted move
    travel_cfg_en_i = 1'b1;
    out_img_i.travel_target_count = exp_pos + 32'd3;
    out_img_i.output_control_word[`PTPI_CTRL_TRAVEL_GO] = 1'b1;
    run(16'h4000, 3, 1);
    chk_cnt(1'b0, 1'b0);
    bchk(in_img_o.input_status_word[`PTPI_STAT_ACK], 1'b1);
    out_img_i.output_control_word[`PTPI_CTRL_TRAVEL_GO] = 1'b0;
    strobe();
    out_img_i.travel_target_count = exp_pos + 32'd50;
    out_img_i.output_control_word[`PTPI_CTRL_TRAVEL_GO] = 1'b1;
    run(16'h4000, 1, 2);
    chk_cnt(1'b0, 1'b0);
    bchk(in_img_o.input_status_word[`PTPI_STAT_ACK], 1'b0);
    out_img_i.output_control_word = 16'h0002;
    travel_cfg_en_i = 1'b0;
    strobe();
    // Ramp on: select change is held back until ramping is inhibited
    out_img_i.output_control_word = 16'h0001;
    ramp_cfg_en_i = 1'b1;
    out_img_i.commanded_frequency = 16'h0100;
    strobe();
    repeat (300) @(posedge core_clk_i);
    strobe();
    bchk(in_img_o.input_status_word[`PTPI_STAT_RAMP], 1'b1);
    bchk(in_img_o.input_status_word[`PTPI_STAT_ACK], 1'b0);
    repeat (2000) @(posedge core_clk_i);
    strobe();
    bchk(in_img_o.input_status_word[`PTPI_STAT_RAMP], 1'b0);
    out_img_i.output_control_word[`PTPI_CTRL_RAMP_INHIBIT] = 1'b1;
    out_img_i.commanded_frequency = 16'h0200;
    strobe();
    strobe();
    bchk(in_img_o.input_status_word[`PTPI_STAT_RAMP], 1'b0);
    bchk(in_img_o.input_status_word[`PTPI_STAT_ACK], 1'b1);
    conclude();
  end

  // Whole sequence needs roughly 48k cycles
  initial begin
    #900000;
    num_errors++;
    conclude();
  end
endmodule : pulse_train_process_image_bench
